// >>> src/snv_defs.vh
// constants for the serial nonvolatile slave front end
`ifndef SNV_DEFS_VH
`define SNV_DEFS_VH

// ****************************************
// op-codes, most significant bit first
// ****************************************
`define SNV_OP_SET_LATCH     8'h06
`define SNV_OP_CLEAR_LATCH   8'h04
`define SNV_OP_STATUS_READ   8'h05
`define SNV_OP_STATUS_WRITE  8'h01
`define SNV_OP_MEM_READ      8'h03
`define SNV_OP_MEM_WRITE     8'h02
`define SNV_OP_SERIAL_WRITE  8'hc2
`define SNV_OP_SERIAL_READ   8'hc3

// ****************************************
// status register field positions
// ****************************************
`define SNV_ST_PROTECT_BIT   7
`define SNV_ST_SPARE_HI      6
`define SNV_ST_SPARE_LO      4
`define SNV_ST_GUARD_HI      3
`define SNV_ST_GUARD_LO      2
`define SNV_ST_LATCH_BIT     1
`define SNV_ST_ZERO_BIT      0

// ****************************************
// reset values and sizes
// ****************************************
`define SNV_ST_NV_RESET      6'h00
`define SNV_SERIAL_RESET     64'h0000000000000000
`define SNV_ADDR_BITS        16
`define SNV_SERIAL_BITS      64
`define SNV_SYNC_STAGES      3
`define SNV_PIN_COUNT        5
// pin vector order: {wp_n, hold_n, si, sck, cs_n}
`define SNV_PIN_RESET        5'h19

`endif

// >>> src/snv_front_end.v
// serial slave front end with status register, array and serial number region
`timescale 1ns/1ps
`default_nettype none
`include "snv_defs.vh"

// What this block does
// - chip select high: standby, output released, all other pins ignored
// - chip select low selects; master lowers it before the first op-code bit
// - pause low: output released, clock and input ignored, still selected
// - input sampled on rising clock edges, output changed on falling edges
// - slave in mode 0 or mode 3, idle clock level either way
// - bit 7 protect enable, nonvolatile, written and read by status commands
// - status writes allowed or blocked by write-protect pin with protect enable
// - bits 6 to 4 spare nonvolatile, store and return written values
// - bits 3 and 2 block guard bits, writable and readable
// - bit 1 write enable latch, set and cleared by latch commands
// - latch readable by status read, status write value for it ignored
// - latch cleared at power-on and on clear-latch command
// - latch stays set after status, serial number or array writes
// - status bit 0 always reads zero
// - main array holds 65,536 bytes behind a 16-bit address
// - separate 64-bit serial number region
// - latch set, clear, status read, write op-codes 06, 04, 05, 01
// - status read shifts 8 bits out and repeats while clocks continue
// - status write takes 8 data bits, positions 1 and 0 discarded
// - chip select rising before op-code completes executes nothing
module snv_front_end #(
    parameter ADDR_BITS = `SNV_ADDR_BITS
) (
    // clock, reset, enable
    input  wire                 clk,
    input  wire                 rst,
    input  wire                 ce,
    // serial pins
    input  wire                 cs_n,
    input  wire                 sck,
    input  wire                 si,
    input  wire                 hold_n,
    input  wire                 wp_n,
    output reg                  so_out,
    output wire                 so_oe,
    // observation of the status register
    output wire [7:0]           status_view
);

    // ****************************************
    // state codes
    // ****************************************
    localparam [2:0] ST_OPCODE = 3'h0;
    localparam [2:0] ST_ADDR   = 3'h1;
    localparam [2:0] ST_READ   = 3'h2;
    localparam [2:0] ST_WRITE  = 3'h3;
    localparam [2:0] ST_IGNORE = 3'h4;

    // ****************************************
    // reset images of the pins and status bits
    // ****************************************
    // held as vectors so that each bit can be picked by a constant index
    localparam [`SNV_PIN_COUNT-1:0] PIN_IDLE = `SNV_PIN_RESET;
    localparam [5:0]                NV_IDLE  = `SNV_ST_NV_RESET;

    // ****************************************
    // pin synchronisers
    // ****************************************
    wire [`SNV_PIN_COUNT-1:0] pin_raw;
    reg  [`SNV_PIN_COUNT-1:0] pin_f;

    assign pin_raw = {wp_n, hold_n, si, sck, cs_n};

    // three flops per pin; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < `SNV_PIN_COUNT; gi = gi + 1) begin : g_sync
            reg [`SNV_SYNC_STAGES-1:0] sync_sh;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    // every stage starts at the idle level, so no false edge after reset
                    sync_sh   <= {`SNV_SYNC_STAGES{PIN_IDLE[gi]}};
                    pin_f[gi] <= PIN_IDLE[gi];
                end else if (ce) begin
                    sync_sh <= {sync_sh[`SNV_SYNC_STAGES-2:0], pin_raw[gi]};
                    if (sync_sh[1] == sync_sh[2]) begin
                        pin_f[gi] <= sync_sh[2];
                    end
                end
            end
        end
    endgenerate

    // filtered levels, in the order of the pin vector
    wire cs_n_f   = pin_f[0];
    wire sck_f    = pin_f[1];
    wire si_f     = pin_f[2];
    wire hold_n_f = pin_f[3];
    wire wp_n_f   = pin_f[4];

    // ****************************************
    // storage
    // ****************************************
    reg [7:0]                  mem [0:(1<<ADDR_BITS)-1];
    reg [`SNV_SERIAL_BITS-1:0] serial_num;
    reg                        serial_locked;
    reg [55:0]                 serial_buf;

    reg                        protect_enable_bit;
    reg [2:0]                  spare_bits;
    reg                        block_guard_hi;
    reg                        block_guard_lo;
    reg                        write_enable_latch;

    // ****************************************
    // shifter and decoder state
    // ****************************************
    reg                        sck_prev;
    reg [2:0]                  bit_cnt;
    reg [6:0]                  rx_sh;
    reg [7:0]                  tx_sh;
    reg [2:0]                  state;
    reg [7:0]                  cmd;
    reg [2:0]                  byte_idx;
    reg [ADDR_BITS-1:0]        addr;
    reg                        mem_we;
    reg [ADDR_BITS-1:0]        mem_wa;
    reg [7:0]                  mem_wd;

    // byte as it stands once the current rising edge is taken
    wire [7:0] byte_in  = {rx_sh, si_f};
    wire       selected = !cs_n_f;
    // pause only matters while selected
    wire       active   = selected && hold_n_f;
    wire       sck_rise = active && sck_f && !sck_prev;
    wire       sck_fall = active && !sck_f && sck_prev;
    wire       byte_done = sck_rise && (bit_cnt == 3'h7);
    wire [ADDR_BITS-1:0] addr_next = {addr[ADDR_BITS-1:8], byte_in};

    // status byte as seen by a status read
    assign status_view = {protect_enable_bit, spare_bits, block_guard_hi,
                          block_guard_lo, write_enable_latch, 1'b0};

    // output driven only while selected and not paused
    assign so_oe = active;

    // write-protect pin low with protect enable set locks the status register
    function status_write_ok;
        input protect_en;
        input wp_level_n;
        begin
            status_write_ok = !(protect_en && !wp_level_n);
        end
    endfunction

    // serial number byte picked by index, first byte most significant
    function [7:0] serial_byte;
        input [63:0] sn;
        input [2:0]  idx;
        begin
            serial_byte = sn[63 - {idx, 3'h0} -: 8];
        end
    endfunction

    // ****************************************
    // array write port
    // ****************************************
    // kept out of the reset process so the array maps to plain memory
    always @(posedge clk) begin
        if (ce && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ****************************************
    // serial engine
    // ****************************************
    // edges of the sampled clock; the idle level is irrelevant, so modes
    // 0 and 3 both work as long as the clock runs under an eighth of clk
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_prev           <= 1'b0;
            bit_cnt            <= 3'h0;
            rx_sh              <= 7'h00;
            tx_sh              <= 8'h00;
            so_out             <= 1'b0;
            state              <= ST_OPCODE;
            cmd                <= 8'h00;
            byte_idx           <= 3'h0;
            addr               <= {ADDR_BITS{1'b0}};
            mem_we             <= 1'b0;
            mem_wa             <= {ADDR_BITS{1'b0}};
            mem_wd             <= 8'h00;
            write_enable_latch <= 1'b0;
            // nonvolatile bits start from their stored image
            protect_enable_bit <= NV_IDLE[5];
            spare_bits         <= NV_IDLE[4:2];
            block_guard_hi     <= NV_IDLE[1];
            block_guard_lo     <= NV_IDLE[0];
            serial_num         <= `SNV_SERIAL_RESET;
            serial_locked      <= 1'b0;
            serial_buf         <= 56'h00000000000000;
        end else if (ce) begin
            mem_we <= 1'b0;
            // held during pause, so a clock level change then counts as an edge once the pause ends
            if (!selected || hold_n_f) begin
                sck_prev <= sck_f;
            end
            if (!selected) begin
                // deselect drops any partial op-code or command
                bit_cnt  <= 3'h0;
                state    <= ST_OPCODE;
                byte_idx <= 3'h0;
                tx_sh    <= 8'h00;
            end else if (sck_fall) begin
                so_out <= tx_sh[7];
                tx_sh  <= {tx_sh[6:0], 1'b0};
            end else if (sck_rise) begin
                rx_sh   <= byte_in[6:0];
                bit_cnt <= bit_cnt + 3'h1;
                if (byte_done) begin
                    case (state)
                        ST_OPCODE: begin
                            cmd      <= byte_in;
                            byte_idx <= 3'h0;
                            case (byte_in)
                                `SNV_OP_SET_LATCH: begin
                                    write_enable_latch <= 1'b1;
                                    state <= ST_IGNORE;
                                end
                                `SNV_OP_CLEAR_LATCH: begin
                                    write_enable_latch <= 1'b0;
                                    state <= ST_IGNORE;
                                end
                                `SNV_OP_STATUS_READ: begin
                                    tx_sh <= status_view;
                                    state <= ST_READ;
                                end
                                `SNV_OP_STATUS_WRITE: begin
                                    state <= ST_WRITE;
                                end
                                `SNV_OP_MEM_READ: begin
                                    state <= ST_ADDR;
                                end
                                `SNV_OP_MEM_WRITE: begin
                                    state <= ST_ADDR;
                                end
                                `SNV_OP_SERIAL_WRITE: begin
                                    state <= ST_WRITE;
                                end
                                `SNV_OP_SERIAL_READ: begin
                                    tx_sh    <= serial_byte(serial_num, 3'h0);
                                    byte_idx <= 3'h1;
                                    state    <= ST_READ;
                                end
                                default: begin
                                    state <= ST_IGNORE;
                                end
                            endcase
                        end
                        ST_ADDR: begin
                            // high byte first, the low byte completes the address
                            if (byte_idx == 3'h0) begin
                                addr[ADDR_BITS-1:8] <= byte_in;
                                byte_idx <= 3'h1;
                            end else if (cmd == `SNV_OP_MEM_READ) begin
                                tx_sh <= mem[addr_next];
                                addr  <= addr_next + 1'b1;
                                state <= ST_READ;
                            end else begin
                                addr  <= addr_next;
                                state <= ST_WRITE;
                            end
                        end
                        ST_READ: begin
                            // reload on every whole byte for repeated reads
                            case (cmd)
                                `SNV_OP_STATUS_READ: begin
                                    tx_sh <= status_view;
                                end
                                `SNV_OP_MEM_READ: begin
                                    tx_sh <= mem[addr];
                                    addr  <= addr + 1'b1;
                                end
                                default: begin
                                    tx_sh    <= serial_byte(serial_num, byte_idx);
                                    byte_idx <= byte_idx + 3'h1;
                                end
                            endcase
                        end
                        ST_WRITE: begin
                            case (cmd)
                                `SNV_OP_STATUS_WRITE: begin
                                    // bits 1 and 0 of the data byte are dropped
                                    if (write_enable_latch &&
                                        status_write_ok(protect_enable_bit,
                                                        wp_n_f)) begin
                                        protect_enable_bit <=
                                            byte_in[`SNV_ST_PROTECT_BIT];
                                        spare_bits <=
                                            byte_in[`SNV_ST_SPARE_HI:`SNV_ST_SPARE_LO];
                                        block_guard_hi <=
                                            byte_in[`SNV_ST_GUARD_HI];
                                        block_guard_lo <=
                                            byte_in[`SNV_ST_GUARD_LO];
                                    end
                                    // latch untouched here, so it stays set
                                    state <= ST_IGNORE;
                                end
                                `SNV_OP_MEM_WRITE: begin
                                    if (write_enable_latch) begin
                                        mem_we <= 1'b1;
                                        mem_wa <= addr;
                                        mem_wd <= byte_in;
                                    end
                                    // address wraps at the top of the array
                                    addr <= addr + 1'b1;
                                end
                                default: begin
                                    // serial number: eight bytes, writable once
                                    serial_buf <= {serial_buf[47:0], byte_in};
                                    byte_idx   <= byte_idx + 3'h1;
                                    if (byte_idx == 3'h7) begin
                                        if (write_enable_latch && !serial_locked) begin
                                            serial_num    <= {serial_buf, byte_in};
                                            serial_locked <= 1'b1;
                                        end
                                        state <= ST_IGNORE;
                                    end
                                end
                            endcase
                        end
                        ST_IGNORE: begin
                            // rest of the frame is dropped until chip select rises
                            state <= ST_IGNORE;
                        end
                        default: begin
                            state <= ST_IGNORE;
                        end
                    endcase
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> verification/snv_front_end_chk.sv
// assertion checker for the serial slave front end
`timescale 1ns/1ps
`default_nettype none
module snv_front_end_chk (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    // serial pins
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       si,
    input wire logic       hold_n,
    input wire logic       wp_n,
    input wire logic       so_out,
    input wire logic       so_oe,
    // status observation
    input wire logic [7:0] status_view
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****************************************
    // pin levels held past the synchroniser lag
    // ****************************************
    sequence s_desel; cs_n [*6]; endsequence
    sequence s_held; !hold_n [*6]; endsequence
    sequence s_live; (!cs_n && hold_n) [*6]; endsequence
    a_oe_off_desel: assert property (s_desel |-> !so_oe)
        else $error("output driven while deselected");
    a_desel_frozen: assert property (s_desel |=> $stable(status_view))
        else $error("status moved while deselected");
    a_oe_on_sel: assert property (s_live |-> so_oe)
        else $error("output not driven while selected");
    a_oe_off_hold: assert property (s_held |-> !so_oe)
        else $error("output driven during pause");
    a_hold_frozen: assert property (s_held |=> $stable(status_view))
        else $error("status moved during pause");
    // output may only move shortly after a falling clock, never near a rise
    a_so_fall_only: assert property ($changed(so_out) && so_oe |-> !$past(sck, 2))
        else $error("serial output moved outside a falling edge");
    a_reset_clear: assert property ($fell(rst) |-> status_view == 8'h00)
        else $error("status not clear after reset");
    a_bit0_zero: assert property (status_view[0] == 1'h0)
        else $error("status bit 0 not zero");
    // write-protect pin is held long before a write, so its old level is what counts
    a_guard_latch: assert property ($changed(status_view[7:2]) |->
        $past(status_view[1]) && !($past(status_view[7]) && !$past(wp_n, 5)))
        else $error("status stored without the latch or against write protect");
endmodule
bind snv_front_end snv_front_end_chk i_chk (
    .clk(clk), .rst(rst), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .status_view(status_view)
);
`default_nettype wire

// >>> verification/snv_spi_master.sv
// serial master model that drives the slave pins
`timescale 1ns/1ps
`default_nettype none
module snv_spi_master (
    // clock
    input  wire logic       clk,
    // pins toward the slave
    output logic            cs_n,
    output logic            sck,
    output logic            si,
    output logic            hold_n,
    input  wire logic       so_out,
    input  wire logic       so_oe,
    // captured bytes
    output logic            rx_valid,
    output logic [7:0]      rx_byte
);
    logic so_last;
    logic idle_hi;
    // a released line has no pull, so it drifts rather than keeping its value
    wire  so_wire = so_oe ? so_out : ~so_last;
    initial begin
        cs_n = 1'h1;
        sck = 1'h0;
        si = 1'h0;
        hold_n = 1'h1;
        rx_valid = 1'h0;
        rx_byte = 8'h00;
        so_last = 1'h0;
        idle_hi = 1'h0;
    end
    always @(posedge clk) if (so_oe) so_last <= so_out;
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    // select with the clock at its idle level; mode 3 idles high
    task automatic sel(input logic m3);
        w(2);
        idle_hi = m3;
        sck <= m3;
        w(4);
        cs_n <= 1'h0;
        w(6);
    endtask
    // one byte or part of one, msb first, optional pause after bit 3
    task automatic xb(input logic [7:0] tx, input int nb, input logic chk, input logic pz);
        logic [7:0] rx;
        rx = 8'h00;
        for (int i = 0; i < nb; i++) begin
            sck <= 1'h0;
            si <= tx[7-i];
            w(4);
            if (pz && i == 3) begin
                hold_n <= 1'h0;
                w(6);
                sck <= 1'h1;
                si <= ~tx[7-i];
                w(4);
                sck <= 1'h0;
                si <= tx[7-i];
                w(4);
                hold_n <= 1'h1;
                w(6);
            end
            sck <= 1'h1;
            w(4);
            rx = {rx[6:0], so_wire}; // sampled late in the high phase, well settled
        end
        if (chk) begin
            rx_byte <= rx;
            rx_valid <= 1'h1;
            w(1);
            rx_valid <= 1'h0;
        end
    endtask
    // back to idle clock, then deselect
    task automatic desel();
        sck <= idle_hi;
        w(4);
        cs_n <= 1'h1;
        si <= ~si;
        w(8);
    endtask
    // clock and data wiggle while deselected
    task automatic noise();
        for (int i = 0; i < 8; i++) begin
            sck <= ~sck;
            si <= ~si;
            w(4);
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the serial slave front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        rst;
    logic        wp_n;
    wire         cs_n, sck, si, hold_n, so_out, so_oe, rx_valid;
    wire  [7:0]  status_view;
    wire  [7:0]  rx_byte;
    logic [7:0]  exp_q[$];
    logic [31:0] seed;
    logic [7:0]  d;
    logic [7:0]  tx_buf [0:9];
    int          failures;
    int          n_compared;
    snv_front_end i_dut (.clk(clk), .rst(rst), .ce(1'h1), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .status_view(status_view));
    snv_spi_master i_master (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .so_out(so_out), .so_oe(so_oe), .rx_valid(rx_valid), .rx_byte(rx_byte));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // status read of two bytes, the second shows the repeat
    task automatic rd(input logic m3, input logic [7:0] e);
        exp_q.push_back(e);
        exp_q.push_back(e);
        i_master.sel(m3);
        i_master.xb(8'h05, 8, 1'h0, 1'h0);
        seed = xs(seed);
        i_master.xb(seed[7:0], 8, 1'h1, 1'h0);
        i_master.xb(seed[15:8], 8, 1'h1, 1'h0);
        i_master.desel();
    endtask
    task automatic cmd(input logic [7:0] op, input int nb, input logic pz);
        i_master.sel(1'h0);
        i_master.xb(op, nb, 1'h0, pz);
        i_master.desel();
    endtask
    task automatic wr(input logic [7:0] v);
        i_master.sel(1'h1);
        i_master.xb(8'h01, 8, 1'h0, 1'h0);
        i_master.xb(v, 8, 1'h0, 1'h0);
        i_master.desel();
    endtask
    // op-code, then n_tx bytes of tx_buf, then n_rx captured bytes
    task automatic frm(input logic [7:0] op, input int n_tx, input int n_rx);
        i_master.sel(1'h0);
        i_master.xb(op, 8, 1'h0, 1'h0);
        for (int j = 0; j < n_tx; j++) begin
            i_master.xb(tx_buf[j], 8, 1'h0, 1'h0);
        end
        for (int j = 0; j < n_rx; j++) begin
            i_master.xb(8'h00, 8, 1'h1, 1'h0);
        end
        i_master.desel();
    endtask
    // results are matched against the oldest note as they arrive
    always @(posedge clk) begin
        if (rx_valid === 1'h1) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("MISMATCH read_byte exp none got %h", rx_byte);
            end else begin
                cmp8("read_byte", exp_q.pop_front(), rx_byte);
            end
        end
    end
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        final_report();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'h1;
        wp_n = 1'h1;
        seed = 32'h1a;
        failures = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        rd(1'h0, 8'h00);
        wr(8'hfc);
        rd(1'h1, 8'h00);
        cmd(8'h06, 8, 1'h0);
        rd(1'h1, 8'h02);
        seed = xs(seed);
        d = seed[7:0] | 8'h80;
        wr(d);
        rd(1'h0, {d[7:2], 2'h2});
        wp_n <= 1'h0;
        wr(~d);
        rd(1'h1, {d[7:2], 2'h2});
        wp_n <= 1'h1;
        cmd(8'h04, 7, 1'h0);
        cmp8("status_view", {d[7:2], 2'h2}, status_view);
        cmd(8'h04, 8, 1'h1);
        rd(1'h0, {d[7:2], 2'h0});
        // a whole set-latch op-code while deselected must change nothing
        i_master.xb(8'h06, 8, 1'h0, 1'h0);
        i_master.noise();
        cmp8("status_view", {d[7:2], 2'h0}, status_view);
        // array: two bytes written at a random address, then read back
        cmd(8'h06, 8, 1'h0);
        seed = xs(seed);
        tx_buf[0] = seed[15:8];
        tx_buf[1] = seed[7:0];
        tx_buf[2] = seed[23:16];
        tx_buf[3] = seed[31:24];
        frm(8'h02, 4, 0);
        exp_q.push_back(tx_buf[2]);
        exp_q.push_back(tx_buf[3]);
        frm(8'h03, 2, 2);
        // serial number: eight random bytes, read back with one wrap
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            tx_buf[k] = seed[7:0];
            exp_q.push_back(seed[7:0]);
        end
        exp_q.push_back(tx_buf[0]);
        frm(8'hc2, 8, 0);
        cmp8("status_view", {d[7:2], 2'h2}, status_view);
        frm(8'hc3, 0, 9);
        for (int k = 0; k < 100 && exp_q.size() > 0; k++) @(posedge clk);
        if (exp_q.size() > 0) failures++;
        final_report();
    end
endmodule
`default_nettype wire
